// ==== inc/cid_defs.vh ====
// Field positions, opcode encodings and timing constants for the compact decoder
`ifndef CID_DEFS_VH
`define CID_DEFS_VH

// Format match patterns on the top bits
`define CID_F1_TOP      3'h0
`define CID_F2_TOP      5'h03
`define CID_F3_TOP      3'h1
`define CID_F4_TOP      6'h10
`define CID_F5_TOP      6'h11

// Shift-immediate opcodes
`define CID_SH_LSL      2'h0
`define CID_SH_LSR      2'h1
`define CID_SH_ASR      2'h2

// Immediate-format opcodes
`define CID_IM_MOV      2'h0
`define CID_IM_CMP      2'h1
`define CID_IM_ADD      2'h2
`define CID_IM_SUB      2'h3

// Two-register ALU opcodes
`define CID_AL_AND      4'h0
`define CID_AL_EOR      4'h1
`define CID_AL_LSL      4'h2
`define CID_AL_LSR      4'h3
`define CID_AL_ASR      4'h4
`define CID_AL_ADC      4'h5
`define CID_AL_SBC      4'h6
`define CID_AL_ROR      4'h7
`define CID_AL_TST      4'h8
`define CID_AL_NEG      4'h9
`define CID_AL_CMP      4'hA
`define CID_AL_CMN      4'hB
`define CID_AL_ORR      4'hC
`define CID_AL_MUL      4'hD
`define CID_AL_BIC      4'hE
`define CID_AL_MVN      4'hF

// High-register opcodes
`define CID_HI_ADD      2'h0
`define CID_HI_CMP      2'h1
`define CID_HI_MOV      2'h2
`define CID_HI_BX       2'h3

// Internal ALU operation codes
`define CID_OP_ADD      4'h0
`define CID_OP_SUB      4'h1
`define CID_OP_ADC      4'h2
`define CID_OP_SBC      4'h3
`define CID_OP_AND      4'h4
`define CID_OP_EOR      4'h5
`define CID_OP_ORR      4'h6
`define CID_OP_BIC      4'h7
`define CID_OP_MVN      4'h8
`define CID_OP_LSL      4'h9
`define CID_OP_LSR      4'hA
`define CID_OP_ASR      4'hB
`define CID_OP_ROR      4'hC
`define CID_OP_MUL      4'hD
`define CID_OP_MOVB     4'hE

// Flag bit positions inside the status word
`define CID_FLAG_N      3
`define CID_FLAG_Z      2
`define CID_FLAG_C      1
`define CID_FLAG_V      0
`define CID_FLAGS_RST   4'h0

// Cycle counts of the equivalent full-width instructions
`define CID_CYC_SIMPLE  3'h1
`define CID_CYC_REGSH   3'h2
`define CID_CYC_MUL     3'h4
`define CID_CYC_BRANCH  3'h3

`endif

// ==== core/cid_alu.v ====
// Combinational 32-bit ALU computing result and condition flags
`timescale 1ns/1ps
`default_nettype none
`include "cid_defs.vh"

module cid_alu #(
  parameter W = 32
) (
  input  wire [3:0]   op,
  input  wire [W-1:0] a,
  input  wire [W-1:0] b,
  input  wire         carry_in,
  output reg  [W-1:0] result,
  output reg  [3:0]   flags
);

  reg  [W:0]   wide;      // Sum with carry out
  reg          c_out;     // Carry or shifter carry
  reg          v_out;     // Overflow
  wire [7:0]   amt;       // Register shift amount, low byte only
  wire [2*W-1:0] prod;    // Full product, low half kept

  assign amt  = b[7:0];
  assign prod = a * b;

  ////////////////////////////////////////////////////////////////
  // Operation select; shifts keep carry when amount is zero
  always @* begin
    wide   = {(W+1){1'b0}};
    c_out  = carry_in;
    v_out  = 1'b0;
    result = {W{1'b0}};
    case (op)
      `CID_OP_ADD, `CID_OP_ADC: begin
        wide   = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, (op == `CID_OP_ADC) & carry_in};
        result = wide[W-1:0];
        c_out  = wide[W];
        v_out  = (a[W-1] == b[W-1]) && (result[W-1] != a[W-1]);
      end
      // Subtract is a plus not b plus carry; borrow is inverted carry
      `CID_OP_SUB, `CID_OP_SBC: begin
        wide   = {1'b0, a} + {1'b0, ~b} +
                 {{W{1'b0}}, (op == `CID_OP_SUB) | carry_in};
        result = wide[W-1:0];
        c_out  = wide[W];
        v_out  = (a[W-1] != b[W-1]) && (result[W-1] != a[W-1]);
      end
      `CID_OP_AND:  result = a & b;
      `CID_OP_EOR:  result = a ^ b;
      `CID_OP_ORR:  result = a | b;
      `CID_OP_BIC:  result = a & ~b;
      `CID_OP_MVN:  result = ~b;
      `CID_OP_MOVB: result = b;
      `CID_OP_MUL:  result = prod[W-1:0];
      `CID_OP_LSL: begin
        if (amt == 8'h00) begin
          result = a;
        end else if (amt < W) begin
          result = a << amt;
          c_out  = a[W - amt];
        end else begin
          result = {W{1'b0}};
          c_out  = (amt == W) ? a[0] : 1'b0;
        end
      end
      `CID_OP_LSR, `CID_OP_ASR: begin
        if (amt == 8'h00) begin
          result = a;
        end else if (amt < W) begin
          // Separate branches: a mixed conditional would make the shift logical
          if (op == `CID_OP_ASR) begin
            result = $signed(a) >>> amt;
          end else begin
            result = a >> amt;
          end
          c_out  = a[amt - 1];
        end else begin
          result = (op == `CID_OP_ASR) ? {W{a[W-1]}} : {W{1'b0}};
          c_out  = (op == `CID_OP_ASR || amt == W) ? a[W-1] : 1'b0;
        end
      end
      // Rotate uses amount modulo width
      `CID_OP_ROR: begin
        if (amt == 8'h00) begin
          result = a;
        end else begin
          result = (a >> amt[4:0]) | (a << (W - amt[4:0]));
          c_out  = result[W-1];
        end
      end
      default: result = {W{1'b0}};
    endcase
    flags = {result[W-1], (result == {W{1'b0}}), c_out, v_out};
  end

endmodule
`default_nettype wire

// ==== core/cid_decode.v ====
// Decode and execute control for compact formats one to five
//
// What this block does
// [RQ1] Shift-immediate: 00 left, 01 right, 10 arithmetic
// [RQ2] Formats one to four always update flags
// [RQ3] Three-operand: op adds/subtracts, I picks immediate
// [RQ4] Immediate format fields: op, destination, byte
// [RQ5] Copy loads byte; compare writes nothing
// [RQ6] ALU logic ops write destination
// [RQ7] ALU register shifts and rotate by source
// [RQ8] Add and subtract with carry
// [RQ9] Test and compares only set flags
// [RQ10] Negate and multiply write destination
// [RQ11] High-register format field positions
// [RQ12] High flags extend registers to 8..15
// [RQ13] Only high compare updates flags
// [RQ14] Software avoids both high flags clear
// [RQ15] Opcode 11 branches to source address
// [RQ16] High add and copy keep flags
// [RQ17] Cycle count matches full-width equivalent
// [RQ18] Target bit 0 picks processor state
// [RQ19] Software avoids branch with first flag
// [RQ20] Shift opcode 11 means add/subtract
`timescale 1ns/1ps
`default_nettype none
`include "cid_defs.vh"

module cid_decode #(
  parameter W = 32
) (
  input  wire         clock,
  input  wire         rst_n,
  input  wire         instr_valid,
  input  wire [15:0]  instr,
  output wire         instr_ready,
  output wire [3:0]   rd_addr_a,
  output wire [3:0]   rd_addr_b,
  input  wire [W-1:0] rd_data_a,
  input  wire [W-1:0] rd_data_b,
  output reg          wr_en,
  output reg  [3:0]   wr_addr,
  output reg  [W-1:0] wr_data,
  output reg          branch_valid,
  output reg  [W-1:0] branch_target,
  output reg          compact_state,
  output reg  [3:0]   status_flags_reg,
  output reg          undef_instr,
  output wire         busy
);

  ////////////////////////////////////////////////////////////////
  // Instruction fields
  wire [1:0] sh_op            = instr[12:11];
  wire [4:0] shift_amount_imm = instr[10:6];
  wire [2:0] src_low_reg      = instr[5:3];
  wire [2:0] dst_low_reg      = instr[2:0];
  wire       imm_sel          = instr[10];
  wire       sub_sel          = instr[9];
  wire [2:0] second_low_reg   = instr[8:6];
  wire [2:0] small_imm        = instr[8:6];
  // [RQ4] Immediate field slicing
  wire [1:0] im_op            = instr[12:11];
  wire [2:0] im_dst           = instr[10:8];
  wire [7:0] byte_imm         = instr[7:0];
  wire [3:0] al_op            = instr[9:6];
  // [RQ11] High-register field slicing
  wire [1:0] hi_op            = instr[9:8];
  wire       first_hi_flag    = instr[7];
  wire       second_hi_flag   = instr[6];
  // [RQ12] High flags extend register numbers
  wire [3:0] dest_high_reg    = {first_hi_flag, dst_low_reg};
  wire [3:0] src_high_reg     = {second_hi_flag, src_low_reg};

  // Format detection; [RQ20] shift opcode 11 falls to add/subtract
  wire is_f1 = (instr[15:13] == `CID_F1_TOP) && (sh_op != `CID_IM_SUB);
  wire is_f2 = (instr[15:11] == `CID_F2_TOP);
  wire is_f3 = (instr[15:13] == `CID_F3_TOP);
  wire is_f4 = (instr[15:10] == `CID_F4_TOP);
  wire is_f5 = (instr[15:10] == `CID_F5_TOP);

  ////////////////////////////////////////////////////////////////
  // Decoded control, combinational
  reg  [3:0]   op;          // ALU operation
  reg  [3:0]   ra;          // Operand A register
  reg  [3:0]   rb;          // Operand B register
  reg          use_imm;     // B from immediate
  reg  [W-1:0] imm;         // Zero-extended immediate
  reg          do_write;    // Writes destination
  reg          do_flags;    // Updates condition flags
  reg          do_branch;   // Branch exchange
  reg          bad;         // Undefined or unsupported
  reg  [3:0]   dst;         // Destination register
  reg  [2:0]   cycles;      // Equivalent cycle count

  always @* begin
    op = `CID_OP_ADD; ra = 4'h0; rb = 4'h0; use_imm = 1'b0;
    imm = {W{1'b0}}; do_write = 1'b0; do_flags = 1'b0;
    do_branch = 1'b0; bad = 1'b0; dst = 4'h0; cycles = `CID_CYC_SIMPLE;
    if (is_f1) begin
      // [RQ1] Shift by five-bit immediate
      ra = {1'b0, src_low_reg}; use_imm = 1'b1; dst = {1'b0, dst_low_reg};
      imm = {{(W-5){1'b0}}, shift_amount_imm};
      op = (sh_op == `CID_SH_LSL) ? `CID_OP_LSL :
           (sh_op == `CID_SH_LSR) ? `CID_OP_LSR : `CID_OP_ASR;
      // Immediate zero on right shifts means shift by full width
      if (sh_op != `CID_SH_LSL && shift_amount_imm == 5'h00) begin
        imm = W;
      end
      do_write = 1'b1;
      // [RQ2] Flags always
      do_flags = 1'b1;
    end else if (is_f2) begin
      // [RQ3] Add or subtract register or small immediate
      ra = {1'b0, src_low_reg}; rb = {1'b0, second_low_reg};
      use_imm = imm_sel; imm = {{(W-3){1'b0}}, small_imm};
      op = sub_sel ? `CID_OP_SUB : `CID_OP_ADD;
      dst = {1'b0, dst_low_reg}; do_write = 1'b1; do_flags = 1'b1;
    end else if (is_f3) begin
      // [RQ5] Byte copy, compare, add, subtract
      ra = {1'b0, im_dst}; dst = {1'b0, im_dst}; use_imm = 1'b1;
      imm = {{(W-8){1'b0}}, byte_imm}; do_flags = 1'b1;
      do_write = (im_op != `CID_IM_CMP);
      op = (im_op == `CID_IM_MOV) ? `CID_OP_MOVB :
           (im_op == `CID_IM_ADD) ? `CID_OP_ADD : `CID_OP_SUB;
    end else if (is_f4) begin
      ra = {1'b0, dst_low_reg}; rb = {1'b0, src_low_reg};
      dst = {1'b0, dst_low_reg}; do_write = 1'b1; do_flags = 1'b1;
      case (al_op)
        // [RQ6] Logic operations
        `CID_AL_AND: op = `CID_OP_AND;
        `CID_AL_EOR: op = `CID_OP_EOR;
        `CID_AL_ORR: op = `CID_OP_ORR;
        `CID_AL_BIC: op = `CID_OP_BIC;
        `CID_AL_MVN: op = `CID_OP_MVN;
        // [RQ7] Register-amount shifts take an extra cycle
        `CID_AL_LSL: begin op = `CID_OP_LSL; cycles = `CID_CYC_REGSH; end
        `CID_AL_LSR: begin op = `CID_OP_LSR; cycles = `CID_CYC_REGSH; end
        `CID_AL_ASR: begin op = `CID_OP_ASR; cycles = `CID_CYC_REGSH; end
        `CID_AL_ROR: begin op = `CID_OP_ROR; cycles = `CID_CYC_REGSH; end
        // [RQ8] Carry-using arithmetic
        `CID_AL_ADC: op = `CID_OP_ADC;
        `CID_AL_SBC: op = `CID_OP_SBC;
        // [RQ9] Flag-only operations
        `CID_AL_TST: begin op = `CID_OP_AND; do_write = 1'b0; end
        `CID_AL_CMP: begin op = `CID_OP_SUB; do_write = 1'b0; end
        `CID_AL_CMN: begin op = `CID_OP_ADD; do_write = 1'b0; end
        // [RQ10] Negate as zero minus source
        `CID_AL_NEG: begin
          op = `CID_OP_SUB; use_imm = 1'b1; imm = {W{1'b0}};
        end
        // [RQ10] Multiply; fixed worst-case latency
        default: begin op = `CID_OP_MUL; cycles = `CID_CYC_MUL; end
      endcase
      // Negate puts zero in A: swap so immediate zero minus source
      if (al_op == `CID_AL_NEG) begin
        ra = {1'b0, src_low_reg};
      end
    end else if (is_f5) begin
      ra = dest_high_reg; rb = src_high_reg; dst = dest_high_reg;
      case (hi_op)
        // [RQ16] High add keeps flags
        `CID_HI_ADD: begin op = `CID_OP_ADD; do_write = 1'b1; end
        // [RQ13] Only compare sets flags here
        `CID_HI_CMP: begin op = `CID_OP_SUB; do_flags = 1'b1; end
        // [RQ16] High copy keeps flags
        `CID_HI_MOV: begin op = `CID_OP_MOVB; do_write = 1'b1; end
        // [RQ15] Branch to source register address
        default: begin
          do_branch = 1'b1; cycles = `CID_CYC_BRANCH;
          // [RQ19] First flag set is flagged undefined
          bad = first_hi_flag;
        end
      endcase
      // [RQ14] Both flags clear is flagged undefined, except for branch exchange
      if (hi_op != `CID_HI_BX && !first_hi_flag && !second_hi_flag) begin
        bad = 1'b1;
      end
    end else begin
      bad = 1'b1;
    end
  end

  // Negate needs immediate in A; realised by routing through operand mux
  wire         neg_sel = is_f4 && (al_op == `CID_AL_NEG);
  wire [W-1:0] opnd_a  = neg_sel ? {W{1'b0}} : rd_data_a;
  wire [W-1:0] opnd_b  = neg_sel ? rd_data_a : (use_imm ? imm : rd_data_b);
  wire [W-1:0] alu_res;
  wire [3:0]   alu_flags;

  assign rd_addr_a = ra;
  assign rd_addr_b = rb;

  cid_alu #(.W(W)) u_alu (
    .op       (op),
    .a        (opnd_a),
    .b        (opnd_b),
    .carry_in (status_flags_reg[`CID_FLAG_C]),
    .result   (alu_res),
    .flags    (alu_flags)
  );

  ////////////////////////////////////////////////////////////////
  // Issue and stall counter
  reg  [2:0] stall_reg;   // Remaining cycles of current instruction
  reg  [2:0] stall_next;
  wire       take = instr_valid && (stall_reg == 3'h0);

  assign instr_ready = (stall_reg == 3'h0);
  assign busy        = (stall_reg != 3'h0);

  // [RQ17] Hold off fetch for the equivalent cycle count
  always @* begin
    stall_next = stall_reg;
    if (take) begin
      stall_next = cycles - `CID_CYC_SIMPLE;
    end else if (stall_reg != 3'h0) begin
      stall_next = stall_reg - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Result registers; undefined encodings write nothing
  always @(posedge clock) begin
    if (!rst_n) begin
      stall_reg        <= 3'h0;
      wr_en            <= 1'b0;
      wr_addr          <= 4'h0;
      wr_data          <= {W{1'b0}};
      branch_valid     <= 1'b0;
      branch_target    <= {W{1'b0}};
      compact_state    <= 1'b1;
      status_flags_reg <= `CID_FLAGS_RST;
      undef_instr      <= 1'b0;
    end else begin
      stall_reg    <= stall_next;
      wr_en        <= take && do_write && !bad;
      branch_valid <= take && do_branch && !bad;
      undef_instr  <= take && bad;
      if (take && do_write && !bad) begin
        wr_addr <= dst;
        wr_data <= alu_res;
      end
      // [RQ2] Flags from the computed result
      if (take && do_flags && !bad) begin
        status_flags_reg <= alu_flags;
      end
      if (take && do_branch && !bad) begin
        // [RQ18] Bit 0 selects the new state, target halfword aligned
        branch_target <= {rd_data_b[W-1:1], 1'b0};
        compact_state <= rd_data_b[0];
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/cid_regfile_model.sv ====
// Register file partner beside the decoder, same-cycle reads
`timescale 1ns/1ps
`default_nettype none
module cid_regfile_model #(parameter W = 32) (
  input  wire logic         clock,
  input  wire logic [3:0]   rd_addr_a,
  input  wire logic [3:0]   rd_addr_b,
  input  wire logic         wr_en,
  input  wire logic [3:0]   wr_addr,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] rd_data_a,
  output logic      [W-1:0] rd_data_b
);
  logic [W-1:0] rf_mem [16];  // Sixteen shared registers
  // Known start pattern, mirrored by the bench's shadow copy
  initial begin
    for (int i = 0; i < 16; i++) rf_mem[i] = W'(32'h13579BDF * i);
  end
  // Write port, one register per pulse
  always @(posedge clock) begin
    if (wr_en) rf_mem[wr_addr] <= wr_data;
  end
  // Combinational reads with write-through bypass, since the decoder's
  // write pulse stands in the same cycle as the next back-to-back take
  assign rd_data_a = (wr_en && wr_addr == rd_addr_a) ? wr_data : rf_mem[rd_addr_a];
  assign rd_data_b = (wr_en && wr_addr == rd_addr_b) ? wr_data : rf_mem[rd_addr_b];
endmodule
`default_nettype wire

// ==== verification/cid_decode_assertions.sv ====
// Port-level timing and decode checks for the compact decoder
`timescale 1ns/1ps
`default_nettype none
module cid_decode_assertions #(parameter W = 32) (
  input wire logic         clock,
  input wire logic         rst_n,
  input wire logic         instr_valid,
  input wire logic [15:0]  instr,
  input wire logic         instr_ready,
  input wire logic         wr_en,
  input wire logic [3:0]   wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic         branch_valid,
  input wire logic [3:0]   status_flags_reg,
  input wire logic         undef_instr
);
  wire tk = instr_valid && instr_ready;        // Instruction taken
  wire f3 = tk && instr[15:13] == 3'h1;        // Immediate format
  wire f4 = tk && instr[15:10] == 6'h10;       // Two-register ALU
  wire f5 = tk && instr[15:10] == 6'h11;       // High-register format
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence stall2; !instr_ready ##1 !instr_ready ##1 instr_ready; endsequence
  sequence stall3; !instr_ready [*3] ##1 instr_ready; endsequence
  mul_stall_a: assert property (f4 && instr[9:6] == 4'hD |=> stall3)
    else $error("multiply stall length wrong");
  shift_stall_a: assert property (
    f4 && instr[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7} |=> !instr_ready ##1 instr_ready)
    else $error("register shift stall length wrong");
  imm_cycle_a: assert property (f3 |=> instr_ready && !undef_instr)
    else $error("immediate op not single cycle");
  cmp_nowrite_a: assert property (f3 && instr[12:11] == 2'h1 |=> !wr_en)
    else $error("immediate compare wrote a register");
  imm_dest_a: assert property (f3 && instr[12:11] != 2'h1 |=>
    wr_en && wr_addr == {1'b0, $past(instr[10:8])}) else $error("immediate destination wrong");
  mov_imm_a: assert property (f3 && instr[12:11] == 2'h0 |=>
    wr_data == {{(W-8){1'b0}}, $past(instr[7:0])}) else $error("byte copy value wrong");
  test_nowrite_a: assert property (f4 && instr[9:6] inside {4'h8, 4'hA, 4'hB} |=> !wr_en)
    else $error("flag-only ALU op wrote a register");
  hi_flags_a: assert property (f5 && instr[9:8] != 2'h1 |=> $stable(status_flags_reg))
    else $error("high add, copy or branch changed flags");
  hi_dest_a: assert property (f5 && !instr[8] && instr[7:6] != 2'h0 |=>
    wr_en && wr_addr == {$past(instr[7]), $past(instr[2:0])}) else $error("high dest wrong");
  bx_take_a: assert property (f5 && instr[9:7] == 3'h6 |=> branch_valid && !wr_en ##0 stall2)
    else $error("branch exchange pulse or stall wrong");
  bx_undef_a: assert property (f5 && instr[9:7] == 3'h7 |=> undef_instr && !branch_valid)
    else $error("branch with first flag not refused");
endmodule
bind cid_decode cid_decode_assertions #(.W(W)) u_chk (.clock(clock), .rst_n(rst_n),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .branch_valid(branch_valid),
  .status_flags_reg(status_flags_reg), .undef_instr(undef_instr));
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the compact decoder with a register file partner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] k; logic [3:0] a; logic [31:0] d; logic [1:0] nz;} cid_note_t;
  logic        clock = 0, rst_n = 0, instr_valid = 0, tk = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  ra, rb, wa, fl;
  logic [31:0] da, db, wd, bt;
  logic        we, bv, cs, ir, ud, bz;
  logic [31:0] sh [16];         // Shadow of the register file
  logic [1:0]  nz = 2'h0;       // Shadow of the N and Z flags
  logic [31:0] lw = 32'h0;      // Last written result, held by the design
  cid_note_t   q [$];           // Expected results, oldest first
  cid_note_t   e;
  integer      seed = 51166, fails = 0, num_checks = 0, f, op;
  cid_decode DUT (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(ir), .rd_addr_a(ra), .rd_addr_b(rb), .rd_data_a(da), .rd_data_b(db),
    .wr_en(we), .wr_addr(wa), .wr_data(wd), .branch_valid(bv), .branch_target(bt),
    .compact_state(cs), .status_flags_reg(fl), .undef_instr(ud), .busy(bz));
  cid_regfile_model u_rf (.clock(clock), .rd_addr_a(ra), .rd_addr_b(rb), .wr_en(we),
    .wr_addr(wa), .wr_data(wd), .rd_data_a(da), .rd_data_b(db));
  initial forever #5 clock = ~clock;
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reference result; k 0 write, 1 flags only, 2 branch, 3 refused
  function cid_note_t pred(input logic [15:0] w);
    logic [31:0] d, s, r;
    logic [3:0]  a;
    logic [1:0]  k;
    logic        fs;
    k = 0; fs = 1; r = 0; a = {1'b0, w[2:0]}; d = sh[a]; s = sh[{1'b0, w[5:3]}];
    if (w[15:11] == 5'h03) begin  // three-operand beats shift 11
      r = w[10] ? {29'h0, w[8:6]} : sh[{1'b0, w[8:6]}];
      r = w[9] ? s - r : s + r;
    end else if (w[15:13] == 3'h0) begin  // shift by immediate
      case (w[12:11]) 0: r = s << w[10:6]; 1: r = s >> w[10:6]; default: r = $signed(s) >>> w[10:6]; endcase
    end else if (w[15:13] == 3'h1) begin  // byte immediate
      a = {1'b0, w[10:8]}; d = sh[a];
      case (w[12:11]) 0: r = w[7:0]; 1: begin r = d - w[7:0]; k = 1; end
        2: r = d + w[7:0]; default: r = d - w[7:0]; endcase
    end else if (w[15:10] == 6'h10) begin  // carry is 1 here
      case (w[9:6]) 0: r = d & s; 1: r = d ^ s; 2: r = d << s[7:0]; 3: r = d >> s[7:0];
        4: r = $signed(d) >>> s[7:0]; 5: r = d + s + 1; 6: r = d - s;
        7: r = (d >> s[4:0]) | (d << (6'd32 - s[4:0])); 8: begin r = d & s; k = 1; end
        9: r = 0 - s; 10: begin r = d - s; k = 1; end 11: begin r = d + s; k = 1; end
        12: r = d | s; 13: r = d * s; 14: r = d & ~s; default: r = ~s; endcase
    end else if (w[15:10] == 6'h11) begin  // high registers
      a = {w[7], w[2:0]}; d = sh[a]; s = sh[{w[6], w[5:3]}]; fs = w[9:8] == 2'h1;
      case (w[9:8]) 0: r = d + s; 1: begin r = d - s; k = 1; end 2: r = s;
        default: begin r = s; k = w[7] ? 2'h3 : 2'h2; end endcase
      if (w[9:8] != 2'h3 && w[7:6] == 2'h0) k = 3;
    end else k = 3;  // Beyond format five
    if (k[1]) fs = 0;
    if (fs) nz = {r[31], r == 0};
    if (k == 0) sh[a] = r;
    return '{k, a, r, nz};
  endfunction
  // Present one word, hold until taken, note the expectation
  task issue(input logic [15:0] w);
    integer n;
    instr <= w;
    instr_valid <= 1'b1;
    @(negedge clock);
    for (n = 0; n < 20 && ir !== 1'b1; n++) @(negedge clock);
    if (n == 20) begin fails++; close_out; end
    @(posedge clock);
    q.push_back(pred(w));
  endtask
  function logic [15:0] mk(input int f, input int op);
    logic [15:0] w;
    w = $random(seed);
    case (f)
      0: begin w[15:11] = {3'h0, op[1:0]}; if (w[10:6] == 5'h00) w[6] = 1'b1; end
      1: w[15:9] = {5'h03, op[1:0]};
      2: w[15:11] = {3'h1, op[1:0]};
      3: w[15:6] = {6'h10, op[3:0]};
      default: begin
        w[15:8] = {6'h11, op[1:0]};
        // no high op other than branch exchange with both flags clear
        if (op[1:0] != 2'h3 && w[7:6] == 2'h0) w[6] = 1'b1;
        if (op[1:0] == 2'h3) w[7] = 1'b0;
      end
    endcase
    return w;
  endfunction
  // Carry ops get a compare with zero first so carry is known set
  task run(input int f, input int op);
    if (f == 3 && (op == 5 || op == 6)) issue(16'h2800);
    issue(mk(f, op));
  endtask
  // Result watcher: one cycle after each take
  always @(negedge clock) begin
    if (tk) begin
      e = q.size() ? q.pop_front() : '1;
      chk(we, e.k == 0); chk(wd, e.k == 0 ? e.d : lw);
      lw = (e.k == 0) ? e.d : lw;
      chk(bv, e.k == 2); chk(ud, e.k == 3);
      chk(fl[3:2], e.nz);
      if (e.k == 0) begin chk(wa, e.a); chk(wd, e.d); end
      if (e.k == 2) begin chk(bt, e.d & ~32'h1); chk(cs, e.d[0]); end
    end
    tk = instr_valid && ir && rst_n;
  end
  initial begin
    for (f = 0; f < 16; f++) sh[f] = 32'h13579BDF * f;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (f = 0; f < 5; f++) for (op = 0; op < 16; op++) if (op < 4 || f == 3) run(f, op);
    $display("test every opcode done");
    issue(16'h4400); issue(16'h4780); issue(16'h4800); issue(16'hE000); issue(16'h4738);
    $display("test refused encodings done");
    for (int i = 0; i < 60; i++) run({$random(seed)} % 5, {$random(seed)} % 16);
    $display("test random stream done");
    instr_valid <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    nz = 2'h0;
    lw = 32'h0;
    @(negedge clock);
    chk(fl, 4'h0); chk(cs, 1'b1); chk(ir, 1'b1); chk(bz, 1'b0);
    chk(wd, 32'h0); chk(we, 1'b0);
    // Back onto the rising edge so the next word is driven there
    @(posedge clock);
    for (op = 0; op < 16; op++) run(3, op);
    instr_valid <= 1'b0;
    repeat (6) @(posedge clock);
    $display("test second reset done");
    close_out;
  end
endmodule
`default_nettype wire
